/* verilog/mwb_defines.svh */
// Offsets, field positions and reset values of the memory window base registers
`ifndef MWB_DEFINES_SVH
`define MWB_DEFINES_SVH

// Primary-port byte offsets
`define P_OFF_DS2 8'h1c
`define P_OFF_DS3 8'h20
`define P_OFF_US1 8'h5c
// Secondary-port byte offsets
`define S_OFF_DS2 8'h5c
`define S_OFF_DS3 8'h60
`define S_OFF_US1 8'h1c

// Field positions inside a window register
`define BAR_SPACE_BIT 0
`define BAR_TYPE_MSB  2
`define BAR_TYPE_LSB  1
`define BAR_PREF_BIT  3
`define BAR_ZERO_MSB  11
`define BAR_ZERO_LSB  4
`define BAR_BASE_MSB  31
`define BAR_BASE_LSB  12
`define BAR_EN_BIT    31

// Halves of the 64-bit primary address
`define ADDR_HI_MSB   63
`define ADDR_HI_LSB   32
`define ADDR_LO_MSB   31
`define ADDR_LO_LSB   0

// Fixed field values
`define BAR_SPACE_MEM 1'b0
`define BAR_TYPE_32   2'b00
`define BAR_RESET     32'h0000_0000
`define BASE_RESET    20'h0_0000

`endif

/* verilog/mwb_pkg.sv */
// Shared types of the memory window base registers
package mwb_pkg;
   typedef logic [31:0] word_t;    // Configuration data word
   typedef logic [19:0] base_t;    // Writable base field, bits 31:12
   typedef logic [7:0]  cfg_addr_t; // Configuration byte offset
   typedef logic [3:0]  be_t;      // Byte enables
   typedef logic [63:0] addr64_t;  // Primary bus address
endpackage

/* verilog/window_base_reg.sv */
// One memory window base register with setup masking and address match
`timescale 1ns/1ps
`include "mwb_defines.svh"
module window_base_reg (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire mwb_pkg::word_t setup,
   input  wire logic          enable,
   input  wire logic          wr_en,
   input  wire mwb_pkg::word_t wr_data,
   input  wire mwb_pkg::be_t   wr_be,
   input  wire mwb_pkg::word_t match_addr,
   output mwb_pkg::base_t      base_ff,
   output mwb_pkg::word_t      rd_word,
   output logic                addr_hit
);
   import mwb_pkg::*;

   base_t mask;     // Writable base bits from setup
   base_t lane_msk; // Bits covered by byte enables
   base_t nxt_base; // Next base value

   // Next base: masked write, cleared while disabled
   always_comb begin
      mask     = setup[`BAR_BASE_MSB:`BAR_BASE_LSB];
      lane_msk = {{8{wr_be[3]}}, {8{wr_be[2]}}, {4{wr_be[1]}}};
      nxt_base = base_ff;
      if (wr_en) begin
         // Only lanes enabled by the access change
         nxt_base = (wr_data[`BAR_BASE_MSB:`BAR_BASE_LSB] & lane_msk) | (base_ff & ~lane_msk);
      end
      nxt_base = nxt_base & mask;
      if (!enable) begin
         nxt_base = `BASE_RESET;
      end
   end

   // Base storage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         base_ff <= `BASE_RESET;
      end else begin
         base_ff <= nxt_base;
      end
   end

   // Read image and address compare
   always_comb begin
      rd_word = `BAR_RESET;
      rd_word[`BAR_SPACE_BIT] = `BAR_SPACE_MEM;
      rd_word[`BAR_TYPE_MSB:`BAR_TYPE_LSB] = `BAR_TYPE_32;
      rd_word[`BAR_PREF_BIT] = setup[`BAR_PREF_BIT];
      // Masked again so a setup change hides stale bits at once
      rd_word[`BAR_BASE_MSB:`BAR_BASE_LSB] = base_ff & mask;
      if (!enable) begin
         rd_word = `BAR_RESET;
      end
      // Bits below 12 never take part in the compare
      addr_hit = enable && ((match_addr[`BAR_BASE_MSB:`BAR_BASE_LSB] & mask) == base_ff);
   end
endmodule // window_base_reg

/* verilog/memory_window_base_registers.sv */
// Three memory window base registers, dual config ports and window claim logic
`timescale 1ns/1ps
`include "mwb_defines.svh"
module memory_window_base_registers (
   input  wire logic               clk,
   input  wire logic               rst,
   // Setup contents, loaded by preload or local processor
   input  wire mwb_pkg::word_t     setup_ds2,
   input  wire mwb_pkg::word_t     setup_ds3,
   input  wire mwb_pkg::word_t     setup_ds3_upper,
   input  wire mwb_pkg::word_t     setup_us1,
   input  wire mwb_pkg::word_t     ds3_upper_base,
   // Primary configuration port
   input  wire logic               p_cfg_rd,
   input  wire logic               p_cfg_wr,
   input  wire mwb_pkg::cfg_addr_t p_cfg_addr,
   input  wire mwb_pkg::be_t       p_cfg_be,
   input  wire mwb_pkg::word_t     p_cfg_wdata,
   output mwb_pkg::word_t          p_cfg_rdata_ff,
   output logic                    p_cfg_ack_ff,
   // Secondary configuration port
   input  wire logic               s_cfg_rd,
   input  wire logic               s_cfg_wr,
   input  wire mwb_pkg::cfg_addr_t s_cfg_addr,
   input  wire mwb_pkg::be_t       s_cfg_be,
   input  wire mwb_pkg::word_t     s_cfg_wdata,
   output mwb_pkg::word_t          s_cfg_rdata_ff,
   output logic                    s_cfg_ack_ff,
   // Primary-side memory request
   input  wire logic               p_req,
   input  wire mwb_pkg::addr64_t   p_addr,
   output logic                    ds2_claim_ff,
   output logic                    ds3_claim_ff,
   output logic                    fwd_down_ff,
   // Secondary-side memory request
   input  wire logic               s_req,
   input  wire mwb_pkg::word_t     s_addr,
   output logic                    us1_claim_ff,
   output logic                    fwd_up_ff
);
   import mwb_pkg::*;

   logic  ds2_en, ds3_en, us1_en;       // Window enables
   logic  p_sel_ds2, p_sel_ds3, p_sel_us1; // Primary decode
   logic  s_sel_ds2, s_sel_ds3, s_sel_us1; // Secondary decode
   logic  ds2_wr, ds3_wr, us1_wr;       // Write strobes
   word_t ds2_wd, ds3_wd, us1_wd;       // Write data
   be_t   ds2_be, ds3_be, us1_be;       // Write byte enables
   word_t ds2_rd, ds3_rd, us1_rd;       // Read images
   base_t ds2_base, ds3_base, us1_base; // Stored bases
   logic  ds2_hit, ds3_lo_hit, us1_hit; // Low-word matches
   logic  ds3_hi_hit;                   // Upper-word match
   word_t nxt_p_rdata, nxt_s_rdata;     // Next read data
   logic  nxt_p_ack, nxt_s_ack;         // Next acks
   logic  nxt_ds2_claim, nxt_ds3_claim, nxt_us1_claim; // Next claims

   // Enables; second downstream stays on while either half is on
   always_comb begin
      ds2_en = setup_ds2[`BAR_EN_BIT];
      ds3_en = setup_ds3[`BAR_EN_BIT] | setup_ds3_upper[`BAR_EN_BIT];
      us1_en = setup_us1[`BAR_EN_BIT];
   end

   // Offset decode for both ports
   always_comb begin
      p_sel_ds2 = (p_cfg_addr == `P_OFF_DS2);
      p_sel_ds3 = (p_cfg_addr == `P_OFF_DS3);
      p_sel_us1 = (p_cfg_addr == `P_OFF_US1);
      s_sel_ds2 = (s_cfg_addr == `S_OFF_DS2);
      s_sel_ds3 = (s_cfg_addr == `S_OFF_DS3);
      s_sel_us1 = (s_cfg_addr == `S_OFF_US1);
   end

   // Write steering; primary wins a same-cycle collision
   always_comb begin
      ds2_wr = (p_cfg_wr & p_sel_ds2) | (s_cfg_wr & s_sel_ds2);
      ds3_wr = (p_cfg_wr & p_sel_ds3) | (s_cfg_wr & s_sel_ds3);
      us1_wr = (p_cfg_wr & p_sel_us1) | (s_cfg_wr & s_sel_us1);
      ds2_wd = (p_cfg_wr & p_sel_ds2) ? p_cfg_wdata : s_cfg_wdata;
      ds3_wd = (p_cfg_wr & p_sel_ds3) ? p_cfg_wdata : s_cfg_wdata;
      us1_wd = (p_cfg_wr & p_sel_us1) ? p_cfg_wdata : s_cfg_wdata;
      ds2_be = (p_cfg_wr & p_sel_ds2) ? p_cfg_be : s_cfg_be;
      ds3_be = (p_cfg_wr & p_sel_ds3) ? p_cfg_be : s_cfg_be;
      us1_be = (p_cfg_wr & p_sel_us1) ? p_cfg_be : s_cfg_be;
   end

   // First downstream window, 32-bit, 2 GB at most
   window_base_reg u_ds2 (
      .clk        (clk),
      .rst        (rst),
      .setup      (setup_ds2),
      .enable     (ds2_en),
      .wr_en      (ds2_wr),
      .wr_data    (ds2_wd),
      .wr_be      (ds2_be),
      .match_addr (p_addr[`ADDR_LO_MSB:`ADDR_LO_LSB]),
      .base_ff    (ds2_base),
      .rd_word    (ds2_rd),
      .addr_hit   (ds2_hit)
   );

   // Second downstream window, low half of a 64-bit range
   window_base_reg u_ds3 (
      .clk        (clk),
      .rst        (rst),
      .setup      (setup_ds3),
      .enable     (ds3_en),
      .wr_en      (ds3_wr),
      .wr_data    (ds3_wd),
      .wr_be      (ds3_be),
      .match_addr (p_addr[`ADDR_LO_MSB:`ADDR_LO_LSB]),
      .base_ff    (ds3_base),
      .rd_word    (ds3_rd),
      .addr_hit   (ds3_lo_hit)
   );

   // Upstream window, 32-bit, 2 GB at most
   window_base_reg u_us1 (
      .clk        (clk),
      .rst        (rst),
      .setup      (setup_us1),
      .enable     (us1_en),
      .wr_en      (us1_wr),
      .wr_data    (us1_wd),
      .wr_be      (us1_be),
      .match_addr (s_addr),
      .base_ff    (us1_base),
      .rd_word    (us1_rd),
      .addr_hit   (us1_hit)
   );

   // Upper address compare; only the second downstream window sees it
   always_comb begin
      ds3_hi_hit = ((p_addr[`ADDR_HI_MSB:`ADDR_HI_LSB] & setup_ds3_upper)
                    == (ds3_upper_base & setup_ds3_upper));
   end

   // Read mux and ack; unmapped offsets read zero
   always_comb begin
      nxt_p_ack   = p_cfg_rd | p_cfg_wr;
      nxt_s_ack   = s_cfg_rd | s_cfg_wr;
      nxt_p_rdata = `BAR_RESET;
      nxt_s_rdata = `BAR_RESET;
      if (p_cfg_rd) begin
         if (p_sel_ds2) begin
            nxt_p_rdata = ds2_rd;
         end else if (p_sel_ds3) begin
            nxt_p_rdata = ds3_rd;
         end else if (p_sel_us1) begin
            nxt_p_rdata = us1_rd;
         end
      end
      if (s_cfg_rd) begin
         if (s_sel_ds2) begin
            nxt_s_rdata = ds2_rd;
         end else if (s_sel_ds3) begin
            nxt_s_rdata = ds3_rd;
         end else if (s_sel_us1) begin
            nxt_s_rdata = us1_rd;
         end
      end
   end

   // Claim decisions for both sides
   always_comb begin
      nxt_ds2_claim = p_req & ds2_hit;
      nxt_ds3_claim = p_req & ds3_lo_hit & ds3_hi_hit;
      nxt_us1_claim = s_req & us1_hit;
   end

   // Registered answers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         p_cfg_rdata_ff <= `BAR_RESET;
         s_cfg_rdata_ff <= `BAR_RESET;
         p_cfg_ack_ff   <= 1'b0;
         s_cfg_ack_ff   <= 1'b0;
         ds2_claim_ff   <= 1'b0;
         ds3_claim_ff   <= 1'b0;
         fwd_down_ff    <= 1'b0;
         us1_claim_ff   <= 1'b0;
         fwd_up_ff      <= 1'b0;
      end else begin
         p_cfg_rdata_ff <= nxt_p_rdata;
         s_cfg_rdata_ff <= nxt_s_rdata;
         p_cfg_ack_ff   <= nxt_p_ack;
         s_cfg_ack_ff   <= nxt_s_ack;
         ds2_claim_ff   <= nxt_ds2_claim;
         ds3_claim_ff   <= nxt_ds3_claim;
         fwd_down_ff    <= nxt_ds2_claim | nxt_ds3_claim;
         us1_claim_ff   <= nxt_us1_claim;
         fwd_up_ff      <= nxt_us1_claim;
      end
   end

   // Checks on the register images and claims
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   space_bit_zero_a: assert property (
      p_cfg_ack_ff |-> (p_cfg_rdata_ff[0] == 1'b0 && s_cfg_rdata_ff[0] == 1'b0))
      else $error("space bit read as one");

   type_field_zero_a: assert property (
      (p_cfg_ack_ff || s_cfg_ack_ff) |-> (p_cfg_rdata_ff[2:1] == 2'b00 && s_cfg_rdata_ff[2:1] == 2'b00))
      else $error("type field not 00");

   pref_bit_read_a: assert property (
      (p_cfg_rd && p_sel_ds2) |=> (p_cfg_rdata_ff[3] == $past(setup_ds2[31] & setup_ds2[3])))
      else $error("prefetch bit wrong");

   low_bits_zero_a: assert property (
      s_cfg_ack_ff |-> (s_cfg_rdata_ff[11:4] == 8'h00))
      else $error("bits 11:4 not zero");

   masked_bits_zero_a: assert property (
      (p_cfg_rd && p_sel_us1) |=> ((p_cfg_rdata_ff[31:12] & ~$past(setup_us1[31:12])) == 20'h0_0000))
      else $error("masked base bit read one");

   write_readback_a: assert property (
      (p_cfg_wr && p_sel_ds2 && p_cfg_be == 4'hf && ds2_en)
      |=> (ds2_base == ($past(p_cfg_wdata[31:12]) & $past(setup_ds2[31:12]))))
      else $error("written base not kept");

   disabled_claim_a: assert property (
      (!setup_us1[31] && s_req) |=> (!us1_claim_ff && (us1_base == 20'h0_0000)))
      else $error("disabled window claimed");

   ds3_both_off_a: assert property (
      (!setup_ds3[31] && !setup_ds3_upper[31] && p_req) |=> !ds3_claim_ff)
      else $error("ds3 claimed while off");

   reset_zero_a: assert property (
      $past(rst) |-> (ds2_base == 20'h0_0000 && ds3_base == 20'h0_0000 && us1_base == 20'h0_0000))
      else $error("base not zero after reset");

   fwd_down_a: assert property (
      (p_req && ds2_hit) |=> (ds2_claim_ff && fwd_down_ff))
      else $error("downstream not forwarded");

   claim_match_a: assert property (
      us1_claim_ff |-> (($past(s_addr[31:12]) & $past(setup_us1[31:12])) == $past(us1_base)))
      else $error("claim without base match");

   pref_bit_sec_a: assert property (
      (s_cfg_rd && s_sel_ds2) |=> (s_cfg_rdata_ff[3] == $past(setup_ds2[31] & setup_ds2[3])))
      else $error("secondary prefetch bit wrong");

   low_bits_prim_a: assert property (
      p_cfg_ack_ff |-> (p_cfg_rdata_ff[11:4] == 8'h00))
      else $error("primary bits 11:4 not zero");

   ds3_mask_kept_a: assert property (
      (ds3_base & ~$past(setup_ds3[31:12])) == 20'h0_0000)
      else $error("ds3 base holds a masked bit");

   lane_keep_a: assert property (
      (p_cfg_wr && p_sel_ds2 && p_cfg_be[3:1] == 3'h0 && !s_cfg_wr && ds2_en)
      |=> (ds2_base == ($past(ds2_base) & $past(setup_ds2[31:12]))))
      else $error("base changed by disabled lanes");

   ds2_off_claim_a: assert property (
      (!setup_ds2[31] && p_req) |=> (!ds2_claim_ff && ds2_base == 20'h0_0000))
      else $error("disabled ds2 claimed");

   ds3_off_base_a: assert property (
      (!setup_ds3[31] && !setup_ds3_upper[31]) |=> (ds3_base == 20'h0_0000))
      else $error("ds3 base kept while off");

   low_addr_free_a: assert property (
      (p_req && ds2_en && ((p_addr[31:12] & setup_ds2[31:12]) == ds2_base)) |=> ds2_claim_ff)
      else $error("claim depended on low address bits");

   ds3_upper_match_a: assert property (
      ds3_claim_ff |-> (($past(p_addr[63:32]) & $past(setup_ds3_upper))
                        == ($past(ds3_upper_base) & $past(setup_ds3_upper))))
      else $error("ds3 claimed off its upper base");

   fwd_up_a: assert property (
      (s_req && us1_hit) |=> (us1_claim_ff && fwd_up_ff))
      else $error("upstream not forwarded");

   read_disabled_a: assert property (
      (s_cfg_rd && s_sel_ds2 && !setup_ds2[31]) |=> (s_cfg_rdata_ff == 32'h0000_0000))
      else $error("disabled window read nonzero");

   ds2_claim_match_a: assert property (
      ds2_claim_ff |-> (($past(p_addr[31:12]) & $past(setup_ds2[31:12])) == $past(ds2_base)))
      else $error("ds2 claim without base match");

   cover_ds2_claim: cover property (p_req && ds2_en ##1 ds2_claim_ff);
   cover_us1_claim: cover property (s_req && us1_en ##1 fwd_up_ff);
   cover_sec_write: cover property (s_cfg_wr && s_sel_ds3 && ds3_en ##1 s_cfg_ack_ff);
   cover_ds3_upper: cover property (p_req && !setup_ds3[31] && ds3_en ##1 ds3_claim_ff);
   cover_off_read: cover property (s_cfg_rd && s_sel_ds2 && !ds2_en ##1 s_cfg_ack_ff);
endmodule // memory_window_base_registers

/* sim/setup_loader.sv */
// Setup loader model standing in for the preload ROM or local processor
`timescale 1ns/1ps
module setup_loader (
   input  wire logic           clk,
   input  wire logic           rst,
   input  wire logic           load,     // Latch new setup contents
   input  wire mwb_pkg::word_t ld_ds2,
   input  wire mwb_pkg::word_t ld_ds3,
   input  wire mwb_pkg::word_t ld_ds3u,
   input  wire mwb_pkg::word_t ld_us1,
   output mwb_pkg::word_t      setup_ds2,
   output mwb_pkg::word_t      setup_ds3,
   output mwb_pkg::word_t      setup_ds3_upper,
   output mwb_pkg::word_t      setup_us1,
   output logic                loaded    // Setup complete, host may access
);
   import mwb_pkg::*;
   // Setup words change only while host accesses are held off
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         setup_ds2       <= 32'h0;
         setup_ds3       <= 32'h0;
         setup_ds3_upper <= 32'h0;
         setup_us1       <= 32'h0;
         loaded          <= 1'b0;
      end else if (load) begin
         setup_ds2       <= ld_ds2;
         setup_ds3       <= ld_ds3;
         setup_ds3_upper <= ld_ds3u;
         setup_us1       <= ld_us1;
         loaded          <= 1'b0;
      end else begin
         loaded          <= 1'b1;
      end
   end
endmodule // setup_loader

/* sim/memory_window_base_registers_tb.sv */
// Self-checking bench for the memory window base registers
`timescale 1ns/1ps
module memory_window_base_registers_tb;
   import mwb_pkg::*;
   logic      clk = 1'b0;                        // Bench clock
   logic      rst = 1'b1;                        // Async reset
   word_t     ld_ds2, ld_ds3, ld_ds3u, ld_us1;   // Loader inputs
   word_t     setup_ds2, setup_ds3, setup_ds3_upper, setup_us1, ds3_upper_base;
   logic      load, loaded, req_d;               // Loader handshake, request seen
   logic      p_cfg_rd, p_cfg_wr, s_cfg_rd, s_cfg_wr, p_req, s_req;
   cfg_addr_t p_cfg_addr, s_cfg_addr;            // Config offsets
   be_t       p_cfg_be, s_cfg_be;                // Byte enables
   word_t     p_cfg_wdata, s_cfg_wdata, p_cfg_rdata_ff, s_cfg_rdata_ff, s_addr, r;
   addr64_t   p_addr;                            // Primary request address
   logic      p_cfg_ack_ff, s_cfg_ack_ff, ds2_claim_ff, ds3_claim_ff;
   logic      fwd_down_ff, us1_claim_ff, fwd_up_ff;
   word_t     cfg_q[$];                          // Expected config answers
   logic [4:0] clm_q[$];                         // Expected claim vectors
   int        fails = 0, comparisons = 0, seed = 45;
   cfg_addr_t offs[7] = '{8'h1c, 8'h20, 8'h5c, 8'h5c, 8'h60, 8'h1c, 8'h40};

   always #4 clk = ~clk;

   memory_window_base_registers dut (.clk, .rst, .setup_ds2, .setup_ds3, .setup_ds3_upper,
      .setup_us1, .ds3_upper_base, .p_cfg_rd, .p_cfg_wr, .p_cfg_addr, .p_cfg_be,
      .p_cfg_wdata, .p_cfg_rdata_ff, .p_cfg_ack_ff, .s_cfg_rd, .s_cfg_wr, .s_cfg_addr,
      .s_cfg_be, .s_cfg_wdata, .s_cfg_rdata_ff, .s_cfg_ack_ff, .p_req, .p_addr,
      .ds2_claim_ff, .ds3_claim_ff, .fwd_down_ff, .s_req, .s_addr, .us1_claim_ff, .fwd_up_ff);
   setup_loader loader (.clk, .rst, .load, .ld_ds2, .ld_ds3, .ld_ds3u, .ld_us1,
      .setup_ds2, .setup_ds3, .setup_ds3_upper, .setup_us1, .loaded);

   // Compare a config answer word
   task cmp_word(word_t got, word_t exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Compare a claim vector
   task cmp_claim(logic [4:0] got, logic [4:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Print counts and verdict, then stop
   task complete_run;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // One config access on either port, expected answer queued
   task cfg(bit sec, bit wr, cfg_addr_t a, be_t be, word_t d, word_t exp);
      @(posedge clk);
      if (sec) begin
         s_cfg_rd <= !wr; s_cfg_wr <= wr; s_cfg_addr <= a; s_cfg_be <= be; s_cfg_wdata <= d;
      end else begin
         p_cfg_rd <= !wr; p_cfg_wr <= wr; p_cfg_addr <= a; p_cfg_be <= be; p_cfg_wdata <= d;
      end
      cfg_q.push_back(wr ? 32'h0 : exp);
      @(posedge clk);
      p_cfg_rd <= 1'b0; p_cfg_wr <= 1'b0; s_cfg_rd <= 1'b0; s_cfg_wr <= 1'b0;
   endtask
   // One memory request, claim vector {ds2,ds3,us1,down,up} queued
   task req(bit sec, addr64_t a, logic [4:0] exp);
      @(posedge clk);
      if (sec) begin
         s_req <= 1'b1; s_addr <= a[31:0];
      end else begin
         p_req <= 1'b1; p_addr <= a;
      end
      clm_q.push_back(exp);
      @(posedge clk);
      p_req <= 1'b0; s_req <= 1'b0;
   endtask
   // Hand setup words to the loader and wait until it is done
   task do_load(word_t a, word_t b, word_t c, word_t d);
      @(posedge clk);
      ld_ds2 <= a; ld_ds3 <= b; ld_ds3u <= c; ld_us1 <= d; load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         #1;
         if (loaded === 1'b1) break;
      end
      if (loaded !== 1'b1) begin
         fails++;
         complete_run;
      end
   endtask

   // Bench copy of request timing
   always @(posedge clk) begin
      req_d <= p_req | s_req;
   end
   // Watcher: each answer takes the oldest note
   always @(negedge clk) begin
      if (p_cfg_ack_ff === 1'b1 || s_cfg_ack_ff === 1'b1) begin
         cmp_word(p_cfg_ack_ff ? p_cfg_rdata_ff : s_cfg_rdata_ff,
                  cfg_q.size() ? cfg_q.pop_front() : 32'hdead_beef);
      end
      if (req_d === 1'b1) begin
         cmp_claim({ds2_claim_ff, ds3_claim_ff, us1_claim_ff, fwd_down_ff, fwd_up_ff},
                   clm_q.size() ? clm_q.pop_front() : 5'h1f);
      end
   end

   // Main sequence
   initial begin
      {ld_ds2, ld_ds3, ld_ds3u, ld_us1, p_cfg_wdata, s_cfg_wdata, s_addr} <= '0;
      {load, p_cfg_rd, p_cfg_wr, s_cfg_rd, s_cfg_wr, p_req, s_req} <= '0;
      {p_cfg_addr, s_cfg_addr, p_cfg_be, s_cfg_be, p_addr} <= '0;
      ds3_upper_base <= 32'h8000_0000;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      foreach (offs[i]) cfg(i inside {[3:5]}, 0, offs[i], 4'hf, 0, 0);
      $display("test reset done");
      do_load(32'hfff0_0008, 32'h0, 32'h8000_0000, 32'hc000_0000);
      cfg(0, 1, 8'h1c, 4'hf, 32'hffff_ffff, 0);
      cfg(0, 0, 8'h1c, 4'hf, 0, 32'hfff0_0008);
      cfg(0, 1, 8'h1c, 4'h1, 32'h0, 0);
      cfg(1, 0, 8'h5c, 4'hf, 0, 32'hfff0_0008);
      r = $random(seed);
      cfg(0, 1, 8'h1c, 4'hf, r, 0);
      cfg(1, 0, 8'h5c, 4'hf, 0, {r[31:20], 20'h0_0008});
      cfg(0, 0, 8'h20, 4'hf, 0, 0);
      req(0, {32'h0, r[31:20], 20'($random(seed))}, 5'b10010);
      req(0, {32'h0, ~r[31], r[30:0]}, 5'b00000);
      req(0, {32'h8000_0000, ~r[31], r[30:0]}, 5'b01010);
      r = $random(seed);
      cfg(1, 1, 8'h1c, 4'hf, r, 0);
      cfg(0, 0, 8'h5c, 4'hf, 0, {r[31:30], 30'h0});
      req(1, {32'h0, r[31:30], 30'($random(seed))}, 5'b00101);
      req(1, {32'h0, ~r[31], r[30:0]}, 5'b00000);
      $display("test enable done");
      do_load(32'h7ff0_0008, 32'h0, 32'h0, 32'h4000_0000);
      cfg(0, 1, 8'h1c, 4'hf, 32'hffff_ffff, 0);
      cfg(1, 0, 8'h5c, 4'hf, 0, 0);
      req(0, {32'h8000_0000, r}, 5'b00000);
      req(1, {32'h0, r}, 5'b00000);
      $display("test disable done");
      repeat (3) @(posedge clk);
      if (cfg_q.size() != 0 || clm_q.size() != 0) fails++;
      complete_run;
   end
endmodule // memory_window_base_registers_tb
